/* File: verilog/tce_cmd_handler.sv */
// Command handler for the sequential copy and the whole-cartridge erase commands.
// Assumes command and parameter bytes arrive in order from same-clock bus logic,
// and that a data mover runs segments and reports each copied block.
//
// Design decisions made here: the plain strobed port and the register addresses.
`include "tce_map.svh"

module tce_cmd_handler (
   input  wire logic                   core_clk,
   input  wire logic                   rst_n,
   input  wire logic [7:0]             reg_addr,
   input  wire logic [31:0]            reg_wdata,
   input  wire logic                   reg_wr,
   input  wire logic                   reg_rd,
   output logic [31:0]                 reg_rdata,
   input  wire logic                   cdb_valid,
   input  wire logic                   cdb_first,
   input  wire logic [7:0]             cdb_byte,
   input  wire logic                   par_valid,
   input  wire logic [7:0]             par_byte,
   output logic                        par_ready,
   output logic                        seg_go,
   output tce_pkg::tce_seg_desc_t      seg_desc,
   input  wire logic                   blk_done,
   input  wire logic                   xfer_err,
   input  wire logic                   err_at_dst,
   output logic                        sense_fetch,
   input  wire logic                   xs_valid,
   input  wire logic                   xs_last,
   input  wire logic [7:0]             xs_byte,
   output logic                        erase_go,
   input  wire logic                   erase_done,
   output logic                        disc_ok,
   output tce_pkg::tce_status_t        status
);
   import tce_pkg::*;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] be32(input logic [7:0] b0, input logic [7:0] b1,
                                        input logic [7:0] b2, input logic [7:0] b3);
      be32 = {b0, b1, b2, b3};
   endfunction

   function automatic logic [15:0] be16(input logic [7:0] b0, input logic [7:0] b1);
      be16 = {b0, b1};
   endfunction

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   tce_state_t     state_q, state_d;
   logic [7:0]     cdb_q [0:5];
   logic [2:0]     cdb_idx_q;
   logic [7:0]     desc_q [0:11];
   logic [3:0]     desc_idx_q;
   logic [1:0]     hdr_idx_q;
   logic [1:0]     cfc_q;
   logic [23:0]    par_cnt_q;
   logic [7:0]     seg_idx_q;
   logic [31:0]    done_q;
   logic [4:0]     xs_idx_q;
   logic           chk_q;
   logic           disc_en_q;
   logic [7:0]     sense_q [0:`TCE_SENSE_DEPTH-1];

   logic           par_ready_q, seg_go_q, fetch_q, erase_go_q, disc_ok_q;
   logic [31:0]    rdata_q;
   tce_seg_desc_t  seg_q;
   tce_status_t    status_q;

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   wire        par_take   = par_valid && par_ready_q;
   wire        cdb_end    = (state_q == TCE_CDB) && cdb_valid && (cdb_idx_q == `TCE_CDB_LAST);
   wire [7:0]  opcode     = cdb_q[0];
   wire [23:0] par_len    = {cdb_q[2], cdb_q[3], cdb_q[4]};
   wire [23:0] par_rem    = par_len - par_cnt_q;
   wire        link_bit   = cdb_q[5][`TCE_LINK_BIT];
   wire        flag_eff   = cdb_q[5][`TCE_FLAG_BIT] && link_bit;
   wire        hdr_end    = (state_q == TCE_HDR) && par_take && (hdr_idx_q == `TCE_HDR_LAST);
   wire [1:0]  cfc_w      = (hdr_idx_q == 2'd0) ? par_byte[4:3] : cfc_q;
   // only the sequential-to-sequential layout is handled here
   wire        cfc_bad    = (cfc_w != `TCE_CFC_SEQSEQ);
   wire        desc_end   = (state_q == TCE_DESC) && par_take && (desc_idx_q == `TCE_DESC_LAST);
   // block count, byte 11 taken straight off the bus
   wire [31:0] desc_cnt   = be32(desc_q[8], desc_q[9], desc_q[10], par_byte);
   // reserved descriptor bytes must be zero
   wire        desc_bad   = (desc_q[2] != 8'h00) || (desc_q[3] != 8'h00);
   wire        long_ok    = cdb_q[1][`TCE_LONG_BIT];
   wire        last_blk   = blk_done && ((done_q + 32'd1) == seg_q.blk_count);
   wire        fetch_end  = (state_q == TCE_FETCH) && xs_valid && xs_last;
   wire        more_par   = (par_cnt_q != par_len);
   // a descriptor must fit in what is left of the list
   wire        short_par  = (par_rem < `TCE_DESC_LEN);
   wire [31:0] residue    = seg_q.blk_count - done_q;

   // Management and command errors, one-cycle events.
   logic       err_w;
   logic       err_valid_w;
   logic [3:0] err_key_w;
   logic [31:0] err_res_w;

   always_comb
   begin
      state_d     = state_q;
      err_w       = 1'b0;
      err_valid_w = 1'b0;
      err_key_w   = `TCE_KEY_ILLEGAL;
      err_res_w   = 32'h0000_0000;
      case (state_q)
         TCE_IDLE:
            if (cdb_valid && cdb_first)
               state_d = TCE_CDB;
         TCE_CDB:
            if (cdb_end)
               state_d = TCE_DECODE;
         TCE_DECODE:
            if (opcode == `TCE_OP_ERASE)
            begin
               // missing long bit is an error
               if (long_ok)
                  state_d = TCE_ERASE;
               else
               begin
                  err_w   = 1'b1;
                  state_d = TCE_STATUS;
               end
            end
            else if (opcode == `TCE_OP_COPY)
               state_d = (par_len == 24'h00_0000) ? TCE_STATUS : TCE_HDR;
            else
            begin
               err_w   = 1'b1;
               state_d = TCE_STATUS;
            end
         TCE_HDR:
            if (hdr_end)
            begin
               // bad parameters end in check condition
               if (cfc_bad || (par_rem < (`TCE_DESC_LEN + 24'd1)))
               begin
                  err_w       = 1'b1;
                  err_valid_w = 1'b1;
                  state_d     = TCE_STATUS;
               end
               else
                  state_d = TCE_DESC;
            end
         TCE_DESC:
            if (desc_end)
            begin
               // invalid descriptor ends in check condition
               if (desc_bad)
               begin
                  err_w       = 1'b1;
                  err_valid_w = 1'b1;
                  err_res_w   = desc_cnt;
                  state_d     = TCE_STATUS;
               end
               else
                  state_d = (desc_cnt == 32'h0000_0000) ? TCE_NEXT : TCE_MOVE;
            end
         TCE_MOVE:
            // fetch the failing device's sense first
            if (xfer_err)
               state_d = TCE_FETCH;
            else if (last_blk)
               state_d = TCE_NEXT;
         TCE_NEXT:
            if (!more_par)
               state_d = TCE_STATUS;
            else if ((seg_idx_q == `TCE_SEG_LAST) || short_par)
            begin
               err_w       = 1'b1;
               err_valid_w = 1'b1;
               state_d     = TCE_STATUS;
            end
            else
               state_d = TCE_DESC;
         TCE_FETCH:
            if (fetch_end)
               state_d = TCE_STATUS;
         TCE_ERASE:
            if (erase_done)
               state_d = TCE_IDLE;
         TCE_STATUS:
            state_d = TCE_IDLE;
         default:
            state_d = TCE_IDLE;
      endcase
      if ((state_q == TCE_ERASE) && erase_done)
         state_d = TCE_STATUS;
   end

   wire chk_d = (state_q == TCE_IDLE) ? 1'b0 : (chk_q || err_w || fetch_end);

   // ----------------------------------------------------------------
   // Sequencing registers
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         state_q    <= TCE_IDLE;
         cdb_idx_q  <= 3'd0;
         hdr_idx_q  <= 2'd0;
         desc_idx_q <= 4'd0;
         cfc_q      <= 2'b00;
         par_cnt_q  <= 24'h00_0000;
         seg_idx_q  <= 8'h00;
         done_q     <= 32'h0000_0000;
         chk_q      <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         chk_q   <= chk_d;
         if (state_q == TCE_IDLE)
            cdb_idx_q <= 3'd1;
         else if ((state_q == TCE_CDB) && cdb_valid)
            cdb_idx_q <= cdb_idx_q + 3'd1;
         if (state_q == TCE_DECODE)
         begin
            hdr_idx_q  <= 2'd0;
            desc_idx_q <= 4'd0;
            par_cnt_q  <= 24'h00_0000;
            seg_idx_q  <= 8'h00;
         end
         if (par_take)
            par_cnt_q <= par_cnt_q + 24'd1;
         if ((state_q == TCE_HDR) && par_take)
         begin
            hdr_idx_q <= hdr_idx_q + 2'd1;
            cfc_q     <= cfc_w;
         end
         if ((state_q == TCE_DESC) && par_take)
            desc_idx_q <= desc_end ? 4'd0 : desc_idx_q + 4'd1;
         if ((state_q == TCE_NEXT) && (state_d == TCE_DESC))
            seg_idx_q <= seg_idx_q + 8'd1;
         if (desc_end)
            done_q <= 32'h0000_0000;
         else if ((state_q == TCE_MOVE) && blk_done)
            done_q <= done_q + 32'd1;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if ((state_q == TCE_IDLE) && cdb_valid && cdb_first)
         cdb_q[0] <= cdb_byte;
      else if ((state_q == TCE_CDB) && cdb_valid)
         cdb_q[cdb_idx_q] <= cdb_byte;
      if ((state_q == TCE_DESC) && par_take)
         desc_q[desc_idx_q] <= par_byte;
   end

   // ----------------------------------------------------------------
   // Segment hand-off
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
         seg_q <= '0;
      else if (desc_end)
      begin
         seg_q.source_ctrl_bus_addr <= desc_q[0][7:5];
         seg_q.source_unit_num      <= desc_q[0][2:0];
         seg_q.dest_ctrl_bus_addr   <= desc_q[1][7:5];
         seg_q.dest_unit_num        <= desc_q[1][2:0];
         seg_q.src_bsize            <= be16(desc_q[4], desc_q[5]);
         seg_q.dst_bsize            <= be16(desc_q[6], desc_q[7]);
         seg_q.blk_count            <= desc_cnt;
      end
   end

   // ----------------------------------------------------------------
   // Extended sense
   // ----------------------------------------------------------------
   // Sense is kept until the next command, so a later request can still read it.
   always_ff @(posedge core_clk)
   begin
      if (!rst_n || ((state_q == TCE_IDLE) && cdb_valid && cdb_first))
      begin
         for (int i = 0; i < `TCE_SENSE_DEPTH; i++)
            sense_q[i] <= 8'h00;
         xs_idx_q <= `TCE_SB_EXT;
      end
      else if (err_w)
      begin
         sense_q[0]          <= `TCE_SENSE_CLASS | (err_valid_w ? `TCE_SENSE_VALID : 8'h00);
         sense_q[`TCE_SB_KEY] <= {4'h0, err_key_w};
         sense_q[`TCE_SB_SEG] <= seg_idx_q;
         {sense_q[3], sense_q[4], sense_q[5], sense_q[6]} <= err_res_w;
      end
      else if ((state_q == TCE_MOVE) && xfer_err)
      begin
         // valid bit, index and copy aborted
         sense_q[0]           <= `TCE_SENSE_CLASS | `TCE_SENSE_VALID;
         sense_q[`TCE_SB_SEG] <= seg_idx_q;
         sense_q[`TCE_SB_KEY] <= {4'h0, `TCE_KEY_ABORTED};
         {sense_q[3], sense_q[4], sense_q[5], sense_q[6]} <= residue;
         // pointer to source status and sense
         sense_q[`TCE_SB_SRC] <= err_at_dst ? 8'h00 : {3'b000, `TCE_SB_EXT};
         // pointer to destination status and sense
         sense_q[`TCE_SB_DST] <= err_at_dst ? {3'b000, `TCE_SB_EXT} : 8'h00;
      end
      else if ((state_q == TCE_FETCH) && xs_valid)
      begin
         // status byte then unmodified sense; surplus bytes overwrite the last sense byte.
         sense_q[xs_idx_q] <= xs_byte;
         if (xs_idx_q != `TCE_SB_EXT_LAST)
            xs_idx_q <= xs_idx_q + 5'd1;
      end
   end

   // ----------------------------------------------------------------
   // Outputs and register port
   // ----------------------------------------------------------------
   wire [31:0] stat_w  = {13'h0000, seg_idx_q, 3'b000, chk_q, 1'b0, cfc_q, state_q};
   wire [31:0] rd_mux  = reg_addr[7]                      ? {24'h00_0000, sense_q[reg_addr[6:2]]} :
                         (reg_addr == `TCE_REG_CTRL)      ? {31'h0000_0000, disc_en_q} :
                         (reg_addr == `TCE_REG_STAT)      ? stat_w :
                         (reg_addr == `TCE_REG_RES)       ? residue : 32'h0000_0000;
   wire        good_end = (state_d == TCE_STATUS) && !chk_d;

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         disc_en_q   <= 1'b0;
         rdata_q     <= 32'h0000_0000;
         par_ready_q <= 1'b0;
         seg_go_q    <= 1'b0;
         fetch_q     <= 1'b0;
         erase_go_q  <= 1'b0;
         disc_ok_q   <= 1'b0;
         status_q    <= '0;
      end
      else
      begin
         if (reg_wr && (reg_addr == `TCE_REG_CTRL))
            disc_en_q <= reg_wdata[0];
         rdata_q     <= reg_rd ? rd_mux : 32'h0000_0000;
         par_ready_q <= (state_d == TCE_HDR) || ((state_d == TCE_DESC) && !desc_end);
         seg_go_q    <= (state_d == TCE_MOVE);
         fetch_q     <= (state_d == TCE_FETCH);
         erase_go_q  <= (state_d == TCE_ERASE);
         // disconnect only while erasing with disconnect enabled
         disc_ok_q   <= (state_d == TCE_ERASE) && disc_en_q;
         // status for every command, linked when good
         status_q.valid     <= (state_d == TCE_STATUS);
         status_q.code      <= chk_d ? `TCE_ST_CHECK :
                               (link_bit ? `TCE_ST_LINKED : `TCE_ST_GOOD);
         status_q.link_next <= good_end && link_bit;
         status_q.flag_irq  <= good_end && flag_eff;
      end
   end

   assign reg_rdata   = rdata_q;
   assign par_ready   = par_ready_q;
   assign seg_go      = seg_go_q;
   assign seg_desc    = seg_q;
   assign sense_fetch = fetch_q;
   assign erase_go    = erase_go_q;
   assign disc_ok     = disc_ok_q;
   assign status      = status_q;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   sequence hdr_wrong_s;
      hdr_end && cfc_bad;
   endsequence
   sequence check_out_s;
      status_q.valid && (status_q.code == `TCE_ST_CHECK);
   endsequence

   cfc_select_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      hdr_wrong_s |=> check_out_s and !par_ready_q)
      else $error("wrong copy function code not refused");

   seg_limit_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (state_q == TCE_NEXT) && more_par && (seg_idx_q == `TCE_SEG_LAST) |=> check_out_s)
      else $error("descriptor past the last index accepted");

   src_fields_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      desc_end && !desc_bad |=> (seg_q.source_ctrl_bus_addr == $past(desc_q[0][7:5]))
                                && (seg_q.source_unit_num == $past(desc_q[0][2:0])))
      else $error("source address or unit misdecoded");

   dst_fields_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      desc_end |=> (seg_q.dest_ctrl_bus_addr == $past(desc_q[1][7:5]))
                   && (seg_q.dest_unit_num == $past(desc_q[1][2:0])))
      else $error("destination address or unit misdecoded");

   block_size_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      desc_end |=> (seg_q.src_bsize == {$past(desc_q[4]), $past(desc_q[5])})
                   && (seg_q.dst_bsize == {$past(desc_q[6]), $past(desc_q[7])}))
      else $error("block size byte order wrong");

   zero_count_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      desc_end && !desc_bad && (desc_cnt == 32'h0000_0000) |=> !seg_go_q [*2])
      else $error("zero count segment started a move");

   bad_desc_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      desc_end && desc_bad |=> check_out_s ##0 (sense_q[0] == 8'hf0))
      else $error("nonzero reserved bytes not refused");

   sequence xfer_fail_s;
      (state_q == TCE_MOVE) && xfer_err;
   endsequence
   abort_sense_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      xfer_fail_s |=> sense_fetch && !status_q.valid
                      && (sense_q[`TCE_SB_KEY] == {4'h0, `TCE_KEY_ABORTED})
                      && (sense_q[`TCE_SB_SEG] == $past(seg_idx_q)))
      else $error("transfer error sense wrong or status too early");

   erase_start_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (state_q == TCE_DECODE) && (opcode == `TCE_OP_ERASE) && long_ok |=> erase_go)
      else $error("erase not started");

   erase_long_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      (state_q == TCE_DECODE) && (opcode == `TCE_OP_ERASE) && !long_ok
      |=> check_out_s and !erase_go)
      else $error("erase without long bit not refused");

   disconnect_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      disc_ok |-> erase_go && $past(disc_en_q))
      else $error("disconnect outside enabled erase");

   flag_link_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      status_q.flag_irq |-> status_q.link_next && status_q.valid)
      else $error("flag interrupt without link");

endmodule // tce_cmd_handler

/* File: verilog/tce_map.svh */
// Offsets, field positions, codes and counts for the tape copy and erase command handler.
// Assumes one core clock and a same-clock command front end feeding bytes in order.
`ifndef TCE_MAP_SVH
`define TCE_MAP_SVH
`define TCE_OP_COPY      8'h18
`define TCE_OP_ERASE     8'h19
`define TCE_CDB_LAST     3'd5
`define TCE_HDR_LAST     2'd3
`define TCE_DESC_LEN     24'd12
`define TCE_DESC_LAST    4'd11
`define TCE_SEG_LAST     8'hff
`define TCE_CFC_SEQSEQ   2'b11
`define TCE_LINK_BIT     0
`define TCE_FLAG_BIT     1
`define TCE_LONG_BIT     0
`define TCE_ST_GOOD      8'h00
`define TCE_ST_CHECK     8'h02
`define TCE_ST_LINKED    8'h10
`define TCE_KEY_ILLEGAL  4'h5
`define TCE_KEY_ABORTED  4'ha
`define TCE_SENSE_CLASS  8'h70
`define TCE_SENSE_VALID  8'h80
`define TCE_SB_SEG       5'd1
`define TCE_SB_KEY       5'd2
`define TCE_SB_RES       5'd3
`define TCE_SB_SRC       5'd8
`define TCE_SB_DST       5'd9
`define TCE_SB_EXT       5'd10
`define TCE_SB_EXT_LAST  5'd31
`define TCE_SENSE_DEPTH  32
`define TCE_REG_CTRL     8'h00
`define TCE_REG_STAT     8'h04
`define TCE_REG_RES      8'h08
`define TCE_REG_SENSE    1'b1
`endif

/* File: verilog/tce_pkg.sv */
// Types shared by the tape copy and erase command handler.
// Assumes the including design also pulls in the constant header.
package tce_pkg;
   typedef enum logic [3:0] {
      TCE_IDLE, TCE_CDB, TCE_DECODE, TCE_HDR, TCE_DESC,
      TCE_MOVE, TCE_NEXT, TCE_FETCH, TCE_ERASE, TCE_STATUS
   } tce_state_t;

   typedef struct packed {
      logic [2:0]  source_ctrl_bus_addr;
      logic [2:0]  source_unit_num;
      logic [2:0]  dest_ctrl_bus_addr;
      logic [2:0]  dest_unit_num;
      logic [15:0] src_bsize;
      logic [15:0] dst_bsize;
      logic [31:0] blk_count;
   } tce_seg_desc_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] code;
      logic       link_next;
      logic       flag_irq;
   } tce_status_t;
endpackage : tce_pkg

/* File: verification/tce_far_model.sv */
// Far side model: data mover, erase mechanics and a failing bus target.
// Assumes the handler's core clock; fail_now is set by the bench to force an error.
module tce_far_model
(
   input  wire logic             core_clk,
   input  wire logic             seg_go,
   input  tce_pkg::tce_seg_desc_t seg_desc,
   input  wire logic             sense_fetch,
   input  wire logic             erase_go,
   input  wire logic             fail_now,
   output logic                  blk_done,
   output logic                  xfer_err,
   output logic                  xs_valid,
   output logic                  xs_last,
   output logic [7:0]            xs_byte,
   output logic                  erase_done
);
   timeunit 1ns;
   timeprecision 1ns;
   import tce_pkg::*;
   logic [31:0] n_q = '0;
   logic [7:0]  k_q = '0;
   logic        t_q = 1'b0;
   initial {blk_done, xfer_err, xs_valid, xs_last, xs_byte, erase_done} = '0;
   // Blocks come every other cycle, so the handler never sees a prompt mover only.
   // paced blocks, status then sense
   always @(posedge core_clk)
   begin
      t_q <= ~t_q;
      blk_done <= 1'b0;
      xfer_err <= 1'b0;
      if (!seg_go) n_q <= '0;
      else if (t_q && !blk_done && !xfer_err && n_q < seg_desc.blk_count)
      begin
         n_q <= n_q + 1;
         if (fail_now && n_q == 1) xfer_err <= 1'b1;
         else blk_done <= 1'b1;
      end
      k_q <= (sense_fetch || erase_go) ? k_q + 8'h01 : 8'h00;
      xs_valid <= sense_fetch && k_q < 3;
      xs_last <= sense_fetch && k_q == 2;
      xs_byte <= (sense_fetch && k_q < 3) ? 8'h02 + k_q : ~xs_byte;
      erase_done <= erase_go && k_q == 6;
   end
endmodule // tce_far_model

/* File: verification/tape_copy_erase_cmd_handler_test.sv */
// Self-checking bench for the tape copy and erase command handler.
// Assumes the far side model file is compiled before this one.
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
   $display("CHECK FAILED %0t got %h exp %h", $time, g, e); end end
module tape_copy_erase_cmd_handler_test
   import tce_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, cdb_valid = 0, cdb_first = 0;
   logic par_valid = 0, fail_now = 0, err_at_dst = 0;
   logic [7:0] reg_addr = '0, cdb_byte = '0, par_byte = '0, xs_byte;
   logic [31:0] reg_wdata = '0, reg_rdata, seed = 32'h3b31, rd_q, r;
   logic par_ready, seg_go, blk_done, xfer_err, sense_fetch, xs_valid, xs_last;
   logic erase_go, erase_done, disc_ok;
   tce_seg_desc_t seg_desc;
   tce_status_t status, st_q;
   int n_errors = 0, n_tests = 0, n_blk = 0;
   tce_cmd_handler dut_u (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .cdb_valid, .cdb_first, .cdb_byte, .par_valid, .par_byte, .par_ready,
      .seg_go, .seg_desc, .blk_done, .xfer_err, .err_at_dst, .sense_fetch, .xs_valid,
      .xs_last, .xs_byte, .erase_go, .erase_done, .disc_ok, .status);
   tce_far_model far_u (.core_clk, .seg_go, .seg_desc, .sense_fetch, .erase_go, .fail_now,
      .blk_done, .xfer_err, .xs_valid, .xs_last, .xs_byte, .erase_done);
   initial forever #10 core_clk = ~core_clk;
   always @(posedge core_clk)
   begin
      if (status.valid === 1'b1) st_q <= status;
      else if (cdb_valid === 1'b1 && cdb_first === 1'b1) st_q <= '0;
      if (cdb_valid === 1'b1 && cdb_first === 1'b1) n_blk <= 0;
      else if (blk_done === 1'b1) n_blk <= n_blk + 1;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic tce_seg_desc_t exp_desc(input logic [11:0] i, input logic [31:0] c);
      return '{i[11:9], i[8:6], i[5:3], i[2:0], 16'h0200, 16'h0100, c};
   endfunction
   task automatic reg_op(input logic w, input logic [7:0] a, input logic [31:0] d);
      reg_wr <= w;
      reg_rd <= !w;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      {reg_wr, reg_rd} <= 2'b00;
      @(posedge core_clk);
      rd_q = reg_rdata;
   endtask
   task automatic sb(input int n);
      reg_op(1'b0, 8'h80 + 8'(4 * n), '0);
   endtask
   task automatic cmd(input logic [47:0] c);
      for (int i = 0; i < 6; i++)
      begin
         {cdb_valid, cdb_first, cdb_byte} <= {1'b1, i == 0, c[47-8*i -: 8]};
         @(posedge core_clk);
      end
      cdb_valid <= 1'b0;
   endtask
   task automatic par(input logic [7:0] b);
      {par_valid, par_byte} <= {1'b1, b};
      do @(posedge core_clk); while (par_ready !== 1'b1);
   endtask
   task automatic wait_st(input logic [7:0] code);
      for (int t = 0; t < 300 && st_q.valid !== 1'b1; t++) @(posedge core_clk);
      `CHK(st_q.valid, 1'b1)
      `CHK(st_q.code, code)
   endtask
   task automatic copy(input logic [7:0] hdr, rsv, input logic [31:0] cnt,
                       input logic [11:0] id);
      logic [127:0] p;
      p = {hdr, 24'h0, id[11:9], 2'b0, id[8:6], id[5:3], 2'b0, id[2:0], rsv, 8'h0,
           16'h0200, 16'h0100, cnt};
      cmd({8'h18, 8'h0, 24'd16, 8'h0});
      for (int i = 0; i < (hdr == 8'h18 ? 16 : 4); i++) par(p[127-8*i -: 8]);
      par_valid <= 1'b0;
      if (cnt != 0 && rsv == 0 && hdr == 8'h18)
      begin
         for (int t = 0; t < 60 && seg_go !== 1'b1; t++) @(posedge core_clk);
         `CHK(seg_go, 1'b1)
         `CHK(seg_desc, exp_desc(id, cnt))
      end
   endtask
   task automatic chk_err(input logic [7:0] key, input logic [31:0] res, s8, s9);
      sb(0); `CHK(rd_q[7:0], 8'hf0)
      sb(1); `CHK(rd_q[7:0], 8'h00)
      sb(2); `CHK(rd_q[7:0], key)
      for (int k = 3; k < 7; k++) begin sb(k); r = {r[23:0], rd_q[7:0]}; end
      `CHK(r, res)
      sb(8); `CHK(rd_q[7:0], s8)
      sb(9); `CHK(rd_q[7:0], s9)
   endtask
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial
   begin
      #100us;
      n_errors++;
      finish_test();
   end
   initial
   begin
      repeat (10) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      reg_op(1'b0, 8'h00, '0); `CHK(rd_q, 32'h0)
      for (int i = 0; i < 4; i++)
      begin
         reg_op(1'b1, 8'h00, {31'h0, i[0]});
         cmd({8'h19, 8'h01, 30'h0, i[1:0]});
         repeat (3) @(posedge core_clk);
         `CHK(disc_ok, i[0])
         wait_st(i[0] ? 8'h10 : 8'h00);
         `CHK(st_q.link_next, i[0])
         `CHK(st_q.flag_irq, i == 3)
      end
      cmd({8'h19, 40'h0});
      wait_st(8'h02);
      sb(0); `CHK(rd_q[7:0], 8'h70)
      $display("erase test finished");
      for (int i = 0; i < 4; i++)
      begin
         seed = lfsr(seed);
         copy(8'h18, 8'h00, i == 0 ? 32'h0 : {30'h0, seed[1:0]} + 1, seed[19:8]);
         wait_st(8'h00);
         `CHK(n_blk, i == 0 ? 0 : int'(seed[1:0]) + 1)
      end
      copy(8'h18, 8'h5a, 32'd2, 12'h0a5);
      wait_st(8'h02);
      chk_err(8'h05, 32'd2, 8'h00, 8'h00);
      copy(8'h08, 8'h00, 32'd1, 12'h000);
      wait_st(8'h02);
      chk_err(8'h05, 32'd0, 8'h00, 8'h00);
      for (int d = 0; d < 2; d++)
      begin
         {fail_now, err_at_dst} <= {1'b1, d[0]};
         copy(8'h18, 8'h00, 32'd3, 12'h321);
         wait_st(8'h02);
         chk_err(8'h0a, 32'd2, d ? 8'h00 : 8'h0a, d ? 8'h0a : 8'h00);
         sb(10); `CHK(rd_q[7:0], 8'h02)
      end
      $display("copy test finished");
      finish_test();
   end
endmodule // tape_copy_erase_cmd_handler_test
